// File: logic/rxcfg_pkg.sv
// Constants for the receiver configuration register bank.
// Assumes a byte-wide register port on core_clk with synchronous reset.
// What this block does
// - Address 16 bits 7..4 hold the passive low-pass bandwidth code, reset 1010.
// - Address 16 bits 3..0 hold the receiver bandwidth code, reset 0011.
// - Address 17 bits 7..4 hold the polyphase centre code, reset 0011, low nibble resets 1000.
// - Address 18 bit 7 turns the polyphase filter on in OOK receive, reset off.
// - Address 18 bit 6 set to one stops the bit synchronizer, reset zero keeps it on.
// - Address 18 bit 5 enables sync word recognition, reset off.
// - Address 18 bits 4..3 pick sync length 8, 16, 24 or 32 bits, reset 11.
// - Address 18 bits 2..1 give the tolerated sync bit errors 0..3, reset zero.
// - Address 19 holds the OOK threshold, reset 00000100.
// - Address 20 reads the signal strength and ignores writes.
// - Address 21 bits 7..5 pick the OOK threshold decrement size, reset 000.
// - Address 21 bits 4..2 pick the OOK threshold decrement rate, reset 000.
// - Address 21 bits 1..0 pick the averaging cutoff, codes 01 and 10 unused, reset 00.
// - With continuous data mode a detected sync word is signalled as the primary event.
// - Four sync bytes, first most significant; the fourth only matches at length 11.
package rxcfg_pkg;
    localparam int          ADDR_W         = 5;
    localparam logic [4:0]  ADDR_FILT_BW   = 5'h10;
    localparam logic [4:0]  ADDR_POLY_CTR  = 5'h11;
    localparam logic [4:0]  ADDR_SYNC_CTRL = 5'h12;
    localparam logic [4:0]  ADDR_OOK_THR   = 5'h13;
    localparam logic [4:0]  ADDR_SIG_STR   = 5'h14;
    localparam logic [4:0]  ADDR_OOK_DYN   = 5'h15;
    localparam logic [4:0]  ADDR_SYNC_B0   = 5'h16;
    localparam logic [4:0]  ADDR_SYNC_B3   = 5'h19;
    localparam logic [7:0]  RST_FILT_BW    = 8'hA3;
    localparam logic [7:0]  RST_POLY_CTR   = 8'h38;
    localparam logic [7:0]  RST_SYNC_CTRL  = 8'h18;
    localparam logic [7:0]  RST_OOK_THR    = 8'h04;
    localparam logic [7:0]  RST_OOK_DYN    = 8'h00;
    localparam logic [7:0]  RST_SYNC_BYTE  = 8'h00;
    localparam int          BIT_POLY_EN    = 7;
    localparam int          BIT_BSYNC_OFF  = 6;
    localparam int          BIT_SYNC_EN    = 5;
    localparam int          SYNC_LEN_HI    = 4;
    localparam int          SYNC_LEN_LO    = 3;
    localparam int          SYNC_TOL_HI    = 2;
    localparam int          SYNC_TOL_LO    = 1;
    localparam logic [1:0]  MODE_CONT      = 2'h0;
    localparam logic [1:0]  AVG_RSVD_A     = 2'h1;
    localparam logic [1:0]  AVG_RSVD_B     = 2'h2;
    localparam logic [1:0]  AVG_SAFE       = 2'h0;
endpackage : rxcfg_pkg

// File: logic/rxcfg_regs.sv
// Receiver configuration registers with sync detection.
// Assumes host port, rx bit stream and signal strength on core_clk.
//
// Local design decision: the address-and-strobe port.
module rxcfg_regs
    import rxcfg_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              reset,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    input  wire logic [7:0]        signal_strength_in,
    input  wire logic [1:0]        data_mode,
    input  wire logic              rx_bit,
    input  wire logic              rx_bit_valid,
    output logic      [3:0]        passive_lpf_bw_code,
    output logic      [3:0]        rx_bw_code,
    output logic      [3:0]        polyphase_center_code,
    output logic                   polyphase_enable,
    output logic                   bitsync_disable,
    output logic      [7:0]        ook_min_threshold,
    output logic      [2:0]        ook_decrement_size,
    output logic      [2:0]        ook_decrement_rate,
    output logic      [1:0]        ook_average_cutoff,
    output logic                   sync_match,
    output logic                   primary_irq
);
    logic [7:0]  filt_r, filt_nxt;
    logic [7:0]  poly_r, poly_nxt;
    logic [7:0]  sctl_r, sctl_nxt;
    logic [7:0]  thr_r, thr_nxt;
    logic [7:0]  dyn_r, dyn_nxt;
    logic [7:0]  sig_r, sig_nxt;
    logic [7:0]  rdata_r, rdata_nxt;
    logic [7:0]  sbyte_r [4];
    logic [7:0]  sbyte_nxt [4];
    logic        irq_r, irq_nxt;
    logic        match_w;

    // True when the address falls inside the sync byte register range
    function automatic logic is_sync_byte(input logic [ADDR_W-1:0] a);
        return (a >= ADDR_SYNC_B0) && (a <= ADDR_SYNC_B3);
    endfunction

    // Register writes; signal strength location ignores writes
    always_comb
    begin
        filt_nxt = filt_r;
        poly_nxt = poly_r;
        sctl_nxt = sctl_r;
        thr_nxt  = thr_r;
        dyn_nxt  = dyn_r;
        sig_nxt  = signal_strength_in;
        for (int i = 0; i < 4; i++)
            sbyte_nxt[i] = sbyte_r[i];
        if (reg_wr)
        begin
            case (reg_addr)
                ADDR_FILT_BW:   filt_nxt = reg_wdata;
                ADDR_POLY_CTR:  poly_nxt = reg_wdata;
                ADDR_SYNC_CTRL: sctl_nxt = reg_wdata;
                ADDR_OOK_THR:   thr_nxt  = reg_wdata;
                ADDR_OOK_DYN:
                begin
                    dyn_nxt = reg_wdata;
                    // Reserved cutoff codes fall back to the default to keep the filter sane
                    if (reg_wdata[1:0] == AVG_RSVD_A || reg_wdata[1:0] == AVG_RSVD_B)
                        dyn_nxt[1:0] = AVG_SAFE;
                end
                default:
                begin
                    if (is_sync_byte(reg_addr))
                        sbyte_nxt[2'(reg_addr - ADDR_SYNC_B0)] = reg_wdata;
                end
            endcase
        end
    end

    // Read mux, data one cycle after the strobe; unmapped reads zero
    always_comb
    begin
        rdata_nxt = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                ADDR_FILT_BW:   rdata_nxt = filt_r;
                ADDR_POLY_CTR:  rdata_nxt = poly_r;
                ADDR_SYNC_CTRL: rdata_nxt = sctl_r;
                ADDR_OOK_THR:   rdata_nxt = thr_r;
                ADDR_SIG_STR:   rdata_nxt = sig_r;
                ADDR_OOK_DYN:   rdata_nxt = dyn_r;
                default:
                begin
                    if (is_sync_byte(reg_addr))
                        rdata_nxt = sbyte_r[2'(reg_addr - ADDR_SYNC_B0)];
                end
            endcase
        end
    end

    // Primary event: sync match in continuous mode
    always_comb
    begin
        irq_nxt = match_w && (data_mode == MODE_CONT);
    end

    // Registers; reset restores every default
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            filt_r  <= RST_FILT_BW;
            poly_r  <= RST_POLY_CTR;
            sctl_r  <= RST_SYNC_CTRL;
            thr_r   <= RST_OOK_THR;
            dyn_r   <= RST_OOK_DYN;
            sig_r   <= 8'h00;
            rdata_r <= 8'h00;
            irq_r   <= 1'b0;
            for (int i = 0; i < 4; i++)
                sbyte_r[i] <= RST_SYNC_BYTE;
        end
        else
        begin
            filt_r  <= filt_nxt;
            poly_r  <= poly_nxt;
            sctl_r  <= sctl_nxt;
            thr_r   <= thr_nxt;
            dyn_r   <= dyn_nxt;
            sig_r   <= sig_nxt;
            rdata_r <= rdata_nxt;
            irq_r   <= irq_nxt;
            for (int i = 0; i < 4; i++)
                sbyte_r[i] <= sbyte_nxt[i];
        end
    end

    // Sync detector, pattern first byte most significant
    rxcfg_sync_det u_sync
    (
        .core_clk     (core_clk),
        .reset        (reset),
        .enable       (sctl_r[BIT_SYNC_EN]),
        .sync_len     (sctl_r[SYNC_LEN_HI:SYNC_LEN_LO]),
        .sync_tol     (sctl_r[SYNC_TOL_HI:SYNC_TOL_LO]),
        .pattern      ({sbyte_r[0], sbyte_r[1], sbyte_r[2], sbyte_r[3]}),
        .rx_bit       (rx_bit),
        .rx_bit_valid (rx_bit_valid),
        .match        (match_w)
    );

    // Field outputs straight from the registers
    assign passive_lpf_bw_code   = filt_r[7:4];
    assign rx_bw_code            = filt_r[3:0];
    assign polyphase_center_code = poly_r[7:4];
    assign polyphase_enable      = sctl_r[BIT_POLY_EN];
    assign bitsync_disable       = sctl_r[BIT_BSYNC_OFF];
    assign ook_min_threshold     = thr_r;
    assign ook_decrement_size    = dyn_r[7:5];
    assign ook_decrement_rate    = dyn_r[4:2];
    assign ook_average_cutoff    = dyn_r[1:0];
    assign sync_match            = match_w;
    assign primary_irq           = irq_r;
    assign reg_rdata             = rdata_r;

    chk_readback_write: assert property (@(posedge core_clk) disable iff (reset)
        reg_wr && reg_addr == ADDR_OOK_THR ##1 reg_rd && reg_addr == ADDR_OOK_THR
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("threshold readback mismatch");
    chk_sig_readonly: assert property (@(posedge core_clk) disable iff (reset)
        reg_rd && reg_addr == ADDR_SIG_STR |=> reg_rdata == $past(sig_r))
        else $error("signal strength readback wrong");
    chk_cutoff_legal: assert property (@(posedge core_clk) disable iff (reset)
        ook_average_cutoff != AVG_RSVD_A && ook_average_cutoff != AVG_RSVD_B)
        else $error("reserved averaging cutoff held");
    chk_irq_from_match: assert property (@(posedge core_clk) disable iff (reset)
        match_w && data_mode == MODE_CONT |=> primary_irq)
        else $error("sync match not signalled");
    chk_reset_defaults: assert property (@(posedge core_clk)
        $past(reset) |-> passive_lpf_bw_code == 4'hA && rx_bw_code == 4'h3
        && ook_min_threshold == RST_OOK_THR)
        else $error("reset defaults wrong");
    chk_sync_off_quiet: assert property (@(posedge core_clk) disable iff (reset)
        !sctl_r[BIT_SYNC_EN] ##1 !sctl_r[BIT_SYNC_EN] |-> !sync_match)
        else $error("match with recognition off");
    chk_ctrl_write: assert property (@(posedge core_clk) disable iff (reset)
        reg_wr && reg_addr == ADDR_SYNC_CTRL |=> polyphase_enable == $past(reg_wdata[7])
        && bitsync_disable == $past(reg_wdata[6]))
        else $error("control write not applied");
    chk_dyn_write: assert property (@(posedge core_clk) disable iff (reset)
        reg_wr && reg_addr == ADDR_OOK_DYN |=> ook_decrement_size == $past(reg_wdata[7:5])
        && ook_decrement_rate == $past(reg_wdata[4:2]))
        else $error("decrement fields not applied");
endmodule // rxcfg_regs

// File: logic/rxcfg_sync_det.sv
// Sync word detector: sliding window compare with error tolerance.
// Assumes rx_bit and rx_bit_valid already on core_clk.
module rxcfg_sync_det
    import rxcfg_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        enable,
    input  wire logic [1:0]  sync_len,
    input  wire logic [1:0]  sync_tol,
    input  wire logic [31:0] pattern,
    input  wire logic        rx_bit,
    input  wire logic        rx_bit_valid,
    output logic             match
);
    logic [31:0] shift_r;
    logic [31:0] shift_nxt;
    logic        match_r;
    logic        match_nxt;
    logic [31:0] diff;
    logic [31:0] mask;
    logic [5:0]  errs;

    // Window mask: fourth byte only counts at the longest length
    always_comb
    begin
        mask = 32'hFF000000;
        case (sync_len)
            2'h1:    mask = 32'hFFFF0000;
            2'h2:    mask = 32'hFFFFFF00;
            2'h3:    mask = 32'hFFFFFFFF;
            default: mask = 32'hFF000000;
        endcase
    end

    // Newest bit lands in bit 0; pattern aligned so its first byte is oldest
    always_comb
    begin
        shift_nxt = shift_r;
        if (rx_bit_valid)
            shift_nxt = {shift_r[30:0], rx_bit};
        diff = (shift_nxt ^ (pattern >> (6'd8 * (6'd3 - {4'h0, sync_len})))) &
               (mask >> (6'd8 * (6'd3 - {4'h0, sync_len})));
        errs = 6'h0;
        for (int i = 0; i < 32; i++)
            errs = errs + {5'h0, diff[i]};
        // One-cycle pulse per received bit that completes a match
        match_nxt = enable && rx_bit_valid && (errs <= {4'h0, sync_tol});
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            shift_r <= 32'h0;
            match_r <= 1'b0;
        end
        else
        begin
            shift_r <= shift_nxt;
            match_r <= match_nxt;
        end
    end

    assign match = match_r;

    chk_match_needs_enable: assert property (@(posedge core_clk) disable iff (reset)
        match |-> $past(enable) && $past(rx_bit_valid))
        else $error("sync match without enable or bit");
endmodule // rxcfg_sync_det

// File: tb/rxcfg_host.sv
// Host model: drives the byte-wide register port of the receiver config bank.
// Assumes the bench calls wr and rd from one process only.
module rxcfg_host
    import rxcfg_pkg::*;
(
    input  wire logic              core_clk,
    output logic      [ADDR_W-1:0] reg_addr,
    output logic      [7:0]        reg_wdata,
    output logic                   reg_wr,
    output logic                   reg_rd
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial
    begin
        reg_addr  = 5'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // One-cycle write; released data is inverted so stale values never match
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
        reg_addr  <= ~a;
    endtask

    // Write then read of the same address with no gap between the strobes
    task automatic wrrd(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        reg_wdata <= ~d;
        @(posedge core_clk);
        reg_rd    <= 1'b0;
        reg_addr  <= ~a;
    endtask

    // One-cycle read strobe; the bench monitor takes the data next cycle
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
    endtask
endmodule // rxcfg_host

// File: tb/tb_receiver_config_registers.sv
// Self-checking bench for the receiver configuration register bank.
// Assumes rxcfg_host drives the register port; rx bits come from this module.
module tb_receiver_config_registers;
    import rxcfg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic              core_clk = 1'b0;
    logic              reset = 1'b1;
    logic              rx_bit = 1'b0;
    logic              rx_bit_valid = 1'b0;
    logic              rx_last = 1'b0;
    logic              rd_d = 1'b0;
    logic              last_d = 1'b0;
    logic              last_d2 = 1'b0;
    logic [1:0]        data_mode = 2'h0;
    logic [7:0]        sig_in = 8'h00;
    logic [ADDR_W-1:0] reg_addr;
    logic [7:0]        reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [7:0]        reg_rdata;
    logic [3:0]        lpf, rxbw, pctr;
    logic              pen, bsoff, sync_match, primary_irq;
    logic [7:0]        thr_o;
    logic [2:0]        dsize, drate;
    logic [1:0]        cut;
    logic [7:0]        f, pc, sc, thr, dyn;
    logic [31:0]       p;
    logic [7:0]        rq[$];
    logic              mq[$];
    logic              iq[$];
    int                n_fail = 0;
    int                check_count = 0;

    rxcfg_host i_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                       .reg_wr(reg_wr), .reg_rd(reg_rd));
    rxcfg_regs i_dut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .signal_strength_in(sig_in), .data_mode(data_mode), .rx_bit(rx_bit),
        .rx_bit_valid(rx_bit_valid), .passive_lpf_bw_code(lpf), .rx_bw_code(rxbw),
        .polyphase_center_code(pctr), .polyphase_enable(pen), .bitsync_disable(bsoff),
        .ook_min_threshold(thr_o), .ook_decrement_size(dsize), .ook_decrement_rate(drate),
        .ook_average_cutoff(cut), .sync_match(sync_match), .primary_irq(primary_irq));

    initial forever #5 core_clk = ~core_clk;

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Field map of the config outputs, built from register images
    function automatic logic [31:0] expo(logic [7:0] a, b, c, t, d);
        return {2'h0, a, b[7:4], c[7], c[6], d[7:5], d[4:2], d[1:0], t};
    endfunction
    wire [31:0] outs = {2'h0, lpf, rxbw, pctr, pen, bsoff, dsize, drate, cut, thr_o};

    task automatic rdx(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        rq.push_back(e);
        i_host.rd(a);
    endtask

    // Shift n bits MSB first, back to back; only the final window is judged
    task automatic send(input logic [31:0] v, input int n, input logic m);
        mq.push_back(m);
        iq.push_back(m && data_mode == 2'h0);
        for (int i = n - 1; i >= 0; i--)
        begin
            @(posedge core_clk);
            rx_bit       <= v[i];
            rx_bit_valid <= 1'b1;
            rx_last      <= (i == 0);
        end
        @(posedge core_clk);
        rx_bit_valid <= 1'b0;
        rx_last      <= 1'b0;
        rx_bit       <= ~v[0];
        repeat (3) @(posedge core_clk);
    endtask

    // Result monitor: read data one cycle after strobe, pulses at fixed lag
    always @(posedge core_clk)
    begin
        rd_d    <= reg_rd;
        last_d  <= rx_last;
        last_d2 <= last_d;
        if (rd_d) chk("reg_rdata", rq.pop_front(), reg_rdata);
        if (last_d) chk("sync_match", mq.pop_front(), sync_match);
        if (last_d2) chk("primary_irq", iq.pop_front(), primary_irq);
    end

    // Hang guard
    initial
    begin
        repeat (30000) @(posedge core_clk);
        $display("Error watchdog expected end seen timeout");
        n_fail++;
        finish_test();
    end

    initial
    begin
        void'($urandom(32'h39493fd8));
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        chk("reset outs", expo(8'hA3, 8'h38, 8'h18, 8'h04, 8'h00), outs);
        rdx(5'h10, 8'hA3);
        rdx(5'h11, 8'h38);
        rdx(5'h12, 8'h18);
        rdx(5'h13, 8'h04);
        rdx(5'h15, 8'h00);
        rdx(5'h16, 8'h00);
        // Random images; decrement size, rate, cutoff and sync length codes swept by the loop index
        for (int i = 0; i < 8; i++)
        begin
            {f, pc, sc, thr} = $urandom;
            dyn = {i[2:0], i[2:0], i[1:0]};
            sc[4:3] = i[1:0];
            sig_in <= $urandom;
            i_host.wr(5'h10, f);
            i_host.wr(5'h11, pc);
            i_host.wr(5'h12, sc);
            rq.push_back(thr);
            i_host.wrrd(5'h13, thr);
            i_host.wr(5'h15, dyn);
            i_host.wr(5'h14, ~sig_in);
            if (dyn[1:0] == 2'h1 || dyn[1:0] == 2'h2) dyn[1:0] = 2'h0;
            @(posedge core_clk);
            chk("outs", expo(f, pc, sc, thr, dyn), outs);
            rdx(5'h10, f);
            rdx(5'h11, pc);
            rdx(5'h12, sc);
            rdx(5'h13, thr);
            rdx(5'h14, sig_in);
            rdx(5'h15, dyn);
            rdx(5'h1F, 8'h00);
        end
        // Reset in mid-run restores defaults
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        chk("rereset outs", expo(8'hA3, 8'h38, 8'h18, 8'h04, 8'h00), outs);
        // Sync pattern, first byte most significant
        p = $urandom;
        for (int b = 0; b < 4; b++) i_host.wr(5'h16 + b[4:0], p[31 - 8 * b -: 8]);
        for (int l = 0; l < 4; l++)
        begin
            data_mode <= l[0] ? 2'h1 : 2'h0;
            i_host.wr(5'h12, {3'b001, l[1:0], l[1:0], 1'b0});
            send((p >> (24 - 8 * l)) ^ ((32'h1 << l) - 1), 8 * (l + 1), 1'b1);
            send((p >> (24 - 8 * l)) ^ ((32'h1 << (l + 1)) - 1), 8 * (l + 1), 1'b0);
        end
        i_host.wr(5'h12, 8'h18);
        send(p, 32, 1'b0);
        if (rq.size() != 0 || mq.size() != 0) chk("queues", 0, 1);
        finish_test();
    end
endmodule // tb_receiver_config_registers
